// ### core/capture_pkg.sv
// Constants for the time stamp capture control block
// What this block does
// - Writing one to the clear bit zeroes all seven captured registers; zero does nothing.
// - The clear bit returns to zero by itself after the clearing.
// - Overwrite select zero: only the first qualifying event while the event flag is clear is captured.
// - Overwrite select one: every qualifying event overwrites the captured time.
// - Overwrite mode captures whatever the event flag shows.
// - Source select zero: pin events make time stamps when capture is enabled.
// - Filter field: 00 edge, 01 256 Hz, 10 64 Hz, 11 8 Hz sampling.
// - Occurrence counter counts every qualifying event in both modes, wrapping to zero.
// - Occurrence counter holds while capture is disabled.
package capture_pkg;
  // Register offsets
  localparam logic [7:0] EVENT_CAPTURE_CONTROL_ADDR = 8'h13;
  localparam logic [7:0] OCCURRENCE_COUNT_ADDR = 8'h14;
  localparam logic [7:0] CAPTURED_TIME_FIRST_ADDR = 8'h15;
  localparam logic [7:0] CAPTURED_TIME_LAST_ADDR = 8'h1a;
  // Control field positions
  localparam int SOURCE_SELECT_BIT = 0;
  localparam int OVERWRITE_SELECT_BIT = 1;
  localparam int CLEAR_BIT_POS = 2;
  localparam int FILTER_LSB = 4;
  localparam int FILTER_MSB = 5;
  localparam int LEVEL_SELECT_BIT = 6;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CAPTURE_RESET = 8'h00;
  // Filter encodings
  localparam logic [1:0] FILTER_NONE = 2'h0;
  localparam logic [1:0] FILTER_256HZ = 2'h1;
  localparam logic [1:0] FILTER_64HZ = 2'h2;
  localparam logic [1:0] FILTER_8HZ = 2'h3;
  // Sampling periods in ns, and clock period in ns
  localparam int unsigned CLOCK_PERIOD_NS = 5;
  localparam int unsigned SAMPLE_256HZ_NS = 3900000;
  localparam int unsigned SAMPLE_64HZ_NS = 15600000;
  localparam int unsigned SAMPLE_8HZ_NS = 125000000;
  localparam int unsigned SAMPLE_256HZ_CYCLES = SAMPLE_256HZ_NS / CLOCK_PERIOD_NS;
  localparam int unsigned SAMPLE_64HZ_CYCLES = SAMPLE_64HZ_NS / CLOCK_PERIOD_NS;
  localparam int unsigned SAMPLE_8HZ_CYCLES = SAMPLE_8HZ_NS / CLOCK_PERIOD_NS;
  localparam int SAMPLE_COUNT_W = 25;
endpackage

// ### core/time_stamp_capture_control.sv
// Time stamp capture control: source select, filtering, first/last capture, clearing
`timescale 1ns/1ps
module time_stamp_capture_control #(
  parameter int unsigned SAMPLE_256HZ_CYCLES = capture_pkg::SAMPLE_256HZ_CYCLES,
  parameter int unsigned SAMPLE_64HZ_CYCLES = capture_pkg::SAMPLE_64HZ_CYCLES,
  parameter int unsigned SAMPLE_8HZ_CYCLES = capture_pkg::SAMPLE_8HZ_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port behind the serial host bus
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Enable and flag handshake with the rest of the device
  input wire logic capture_enable,
  input wire logic event_flag_clear,
  output logic event_flag,
  // Event sources
  input wire logic event_input_pin,
  input wire logic backup_supply_operation,
  // Live time, BCD: seconds, minutes, hours, date, month, year
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_date,
  input wire logic [7:0] time_month,
  input wire logic [7:0] time_year
);
  import capture_pkg::*;

  // Sample counter must hold the longest period
  if (SAMPLE_8HZ_CYCLES >= (64'd1 << SAMPLE_COUNT_W) || SAMPLE_256HZ_CYCLES < 2 ||
      SAMPLE_64HZ_CYCLES < 2 || SAMPLE_8HZ_CYCLES < 2) begin : g_bad_period
    $error("Sampling period out of range for the sample counter");
  end

  logic capture_source_select;
  logic capture_overwrite_select;
  logic capture_clear_bit;
  logic level_select;
  logic [1:0] event_filter_select;
  logic [7:0] event_occurrence_counter;
  logic [7:0] captured [0:5];
  logic [SAMPLE_COUNT_W-1:0] sample_cnt;
  logic [SAMPLE_COUNT_W-1:0] sample_limit;
  logic [1:0] sample_hist;
  logic pin_q;
  logic backup_q;
  logic sample_tick;
  logic pin_event;
  logic backup_event;
  logic qualifying;
  logic ctrl_write;
  logic [7:0] live_time [0:5];

  assign live_time[0] = time_sec;
  assign live_time[1] = time_min;
  assign live_time[2] = time_hour;
  assign live_time[3] = time_date;
  assign live_time[4] = time_month;
  assign live_time[5] = time_year;
  assign ctrl_write = reg_write && (reg_addr == EVENT_CAPTURE_CONTROL_ADDR);

  // Control register; level select is kept for read-back only
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_source_select <= CONTROL_RESET[SOURCE_SELECT_BIT];
      capture_overwrite_select <= CONTROL_RESET[OVERWRITE_SELECT_BIT];
      event_filter_select <= CONTROL_RESET[FILTER_MSB:FILTER_LSB];
      level_select <= CONTROL_RESET[LEVEL_SELECT_BIT];
    end else if (ctrl_write) begin
      capture_source_select <= reg_wdata[SOURCE_SELECT_BIT];
      capture_overwrite_select <= reg_wdata[OVERWRITE_SELECT_BIT];
      event_filter_select <= reg_wdata[FILTER_MSB:FILTER_LSB];
      level_select <= reg_wdata[LEVEL_SELECT_BIT];
    end
  end

  // self clearing
  // Bit lives one cycle, the cycle in which the clearing happens
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_clear_bit <= CONTROL_RESET[CLEAR_BIT_POS];
    end else begin
      capture_clear_bit <= ctrl_write && reg_wdata[CLEAR_BIT_POS];
    end
  end

  always_comb begin
    unique case (event_filter_select)
      FILTER_NONE: sample_limit = '0;
      FILTER_256HZ: sample_limit = SAMPLE_COUNT_W'(SAMPLE_256HZ_CYCLES - 1);
      FILTER_64HZ: sample_limit = SAMPLE_COUNT_W'(SAMPLE_64HZ_CYCLES - 1);
      FILTER_8HZ: sample_limit = SAMPLE_COUNT_W'(SAMPLE_8HZ_CYCLES - 1);
    endcase
  end

  // Free running sample divider, restarted when the period changes
  always_ff @(posedge mclk) begin
    if (reset || ctrl_write || sample_cnt >= sample_limit) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + 1'b1;
    end
  end
  assign sample_tick = (sample_cnt >= sample_limit);

  // Pin history: raw previous level and filtered sample pair
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_q <= 1'b0;
      backup_q <= 1'b0;
      sample_hist <= 2'h0;
    end else begin
      pin_q <= event_input_pin;
      backup_q <= backup_supply_operation;
      if (sample_tick) begin
        sample_hist <= {sample_hist[0], event_input_pin};
      end
    end
  end

  // edge or stable state
  // Filtered mode needs two high samples after a low one, so glitches shorter than a period vanish
  always_comb begin
    if (event_filter_select == FILTER_NONE) begin
      pin_event = event_input_pin && !pin_q;
    end else begin
      pin_event = sample_tick && event_input_pin && (sample_hist == 2'h1);
    end
  end

  assign backup_event = backup_supply_operation && !backup_q;
  assign qualifying = capture_enable && (capture_source_select ? backup_event : pin_event);

  // occurrence counter
  // Clearing wins over a coincident event so a cleared counter reads zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      event_occurrence_counter <= CAPTURE_RESET;
    end else if (capture_clear_bit) begin
      event_occurrence_counter <= CAPTURE_RESET;
    end else if (qualifying) begin
      event_occurrence_counter <= event_occurrence_counter + 8'h01;
    end
  end

  for (genvar i = 0; i < 6; i++) begin : g_capture
    always_ff @(posedge mclk) begin
      if (reset || capture_clear_bit) begin
        captured[i] <= CAPTURE_RESET;
      end else if (qualifying && (capture_overwrite_select || !event_flag)) begin
        captured[i] <= live_time[i];
      end
    end
  end

  // flag arms first-event capture; a new event beats a clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      event_flag <= 1'b0;
    end else if (qualifying) begin
      event_flag <= 1'b1;
    end else if (event_flag_clear) begin
      event_flag <= 1'b0;
    end
  end

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == EVENT_CAPTURE_CONTROL_ADDR) begin
      reg_rdata <= {1'b0, level_select, event_filter_select, 1'b0, capture_clear_bit,
                    capture_overwrite_select, capture_source_select};
    end else if (reg_addr == OCCURRENCE_COUNT_ADDR) begin
      reg_rdata <= event_occurrence_counter;
    end else if (reg_addr >= CAPTURED_TIME_FIRST_ADDR && reg_addr <= CAPTURED_TIME_LAST_ADDR) begin
      reg_rdata <= captured[3'(reg_addr - CAPTURED_TIME_FIRST_ADDR)];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks next to the logic
  sequence clear_request_s;
    ctrl_write && reg_wdata[CLEAR_BIT_POS];
  endsequence

  sequence clear_done_s;
    capture_clear_bit ##1 (event_occurrence_counter == 8'h00 && captured[0] == 8'h00 && captured[5] == 8'h00);
  endsequence

  AST_CLEAR_ZEROES: assert property (@(posedge mclk) disable iff (reset)
    clear_request_s |=> clear_done_s) else $error("Clear bit did not zero captured registers");

  AST_CLEAR_SELF: assert property (@(posedge mclk) disable iff (reset)
    capture_clear_bit && !(ctrl_write && reg_wdata[CLEAR_BIT_POS]) |=> !capture_clear_bit)
    else $error("Clear bit did not return to zero");

  AST_NO_CLEAR_ON_ZERO: assert property (@(posedge mclk) disable iff (reset)
    ctrl_write && !reg_wdata[CLEAR_BIT_POS] && !qualifying && !capture_clear_bit
    |=> $stable(event_occurrence_counter))
    else $error("Writing zero to clear bit changed the counter");

  AST_FIRST_KEEPS: assert property (@(posedge mclk) disable iff (reset)
    event_flag && !capture_overwrite_select && !capture_clear_bit |=> $stable(captured[0]))
    else $error("First-event capture was overwritten");

  AST_LAST_OVERWRITES: assert property (@(posedge mclk) disable iff (reset)
    qualifying && capture_overwrite_select && !capture_clear_bit |=> captured[1] == $past(time_min))
    else $error("Last-event capture missed an event");

  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (reset)
    qualifying && !capture_clear_bit |=> event_occurrence_counter == $past(event_occurrence_counter) + 8'h01)
    else $error("Counter did not step on event");

  AST_COUNT_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !capture_enable && !capture_clear_bit |=> $stable(event_occurrence_counter))
    else $error("Counter moved while capture disabled");

  AST_BACKUP_SOURCE: assert property (@(posedge mclk) disable iff (reset)
    capture_source_select && capture_enable && $rose(backup_supply_operation) && !capture_clear_bit
    |=> event_flag && event_occurrence_counter == $past(event_occurrence_counter) + 8'h01)
    else $error("Backup switchover did not make a time stamp");

  AST_PIN_EDGE: assert property (@(posedge mclk) disable iff (reset)
    !capture_source_select && capture_enable && event_filter_select == FILTER_NONE &&
    $rose(event_input_pin) |=> event_flag) else $error("Pin edge did not set event flag");

  AST_FILTER_QUIET: assert property (@(posedge mclk) disable iff (reset)
    !capture_source_select && event_filter_select != FILTER_NONE && !sample_tick && !capture_clear_bit
    |=> $stable(event_occurrence_counter)) else $error("Filtered input counted between samples");
endmodule

// ### test/event_source_model.sv
// Far side model: event pin source and supply switchover
`timescale 1ns/1ps
module event_source_model (
  // Clock
  input wire logic mclk,
  // Levels asked for by the bench
  input wire logic pin_level,
  input wire logic backup_level,
  // Lines into the block
  output logic event_input_pin,
  output logic backup_supply_operation
);
  // Lines follow the bench's levels one edge later; one driver each, settled well inside reset
  always @(posedge mclk) begin
    event_input_pin <= pin_level;
    backup_supply_operation <= backup_level;
  end
endmodule

// ### test/time_stamp_capture_control_bench.sv
// Self-checking bench for the time stamp capture control block
`timescale 1ns/1ps
module time_stamp_capture_control_bench;
  import capture_pkg::*;
  logic mclk, reset, reg_write, capture_enable, event_flag_clear, pin_level, backup_level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic event_flag, event_input_pin, backup_supply_operation, ow, flag_exp;
  logic [7:0] tm [6];
  logic [7:0] exp_cap [6];
  logic [7:0] exp_count;
  int mismatches = 0, samples_checked = 0, cycles = 0, seed, i;

  time_stamp_capture_control #(.SAMPLE_256HZ_CYCLES(4), .SAMPLE_64HZ_CYCLES(8), .SAMPLE_8HZ_CYCLES(16)) u_time_stamp_capture_control (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .capture_enable(capture_enable), .event_flag_clear(event_flag_clear),
    .event_flag(event_flag), .event_input_pin(event_input_pin), .backup_supply_operation(backup_supply_operation),
    .time_sec(tm[0]), .time_min(tm[1]), .time_hour(tm[2]), .time_date(tm[3]), .time_month(tm[4]), .time_year(tm[5]));
  event_source_model u_event_source_model (.mclk(mclk), .pin_level(pin_level), .backup_level(backup_level),
    .event_input_pin(event_input_pin), .backup_supply_operation(backup_supply_operation));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Hang guard, well above the longest expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // Random BCD digit pair, kept to 00..59
  function automatic logic [7:0] bcd(input int r);
    int v;
    v = (r & 32'h7fffffff) % 60;
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  // Counter moves on with natural wrap past ff
  function automatic logic [7:0] next_count(input logic [7:0] c);
    return c + 8'h01;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  // Read data is registered, so it lands one edge after the address; sampled after two
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 d = reg_rdata;
  endtask
  task automatic check_all();
    logic [7:0] v;
    #1 chk("flag", {7'h00, flag_exp}, {7'h00, event_flag});
    rd_reg(OCCURRENCE_COUNT_ADDR, v);
    chk("count", exp_count, v);
    for (int k = 0; k < 6; k++) begin
      rd_reg(CAPTURED_TIME_FIRST_ADDR + 8'(k), v);
      chk("capture", exp_cap[k], v);
    end
  endtask
  // One event of given length; time held steady across it
  task automatic fire(input logic backup, input int hold);
    @(posedge mclk);
    for (int k = 0; k < 6; k++) tm[k] <= bcd($random(seed));
    if (backup) backup_level <= 1'b1;
    else pin_level <= 1'b1;
    repeat (hold) @(posedge mclk);
    backup_level <= 1'b0;
    pin_level <= 1'b0;
    repeat (hold + 4) @(posedge mclk);
  endtask
  task automatic expect_event();
    exp_count = next_count(exp_count);
    if (ow || !flag_exp) for (int k = 0; k < 6; k++) exp_cap[k] = tm[k];
    flag_exp = 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h829a24f9;
    {reset, reg_write, reg_addr, reg_wdata, capture_enable, event_flag_clear} = {2'b10, 16'h0, 2'b00};
    {pin_level, backup_level, ow, flag_exp, exp_count} = '0;
    for (int k = 0; k < 6; k++) {tm[k], exp_cap[k]} = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(EVENT_CAPTURE_CONTROL_ADDR, rd);
    chk("control", CONTROL_RESET, rd);
    check_all();
    @(posedge mclk) capture_enable <= 1'b1;
    for (i = 0; i < 3; i++) begin
      fire(1'b0, 2);
      expect_event();
    end
    check_all();
    @(posedge mclk);
    event_flag_clear <= 1'b1;
    @(posedge mclk);
    event_flag_clear <= 1'b0;
    flag_exp = 1'b0;
    check_all();
    fire(1'b0, 2);
    expect_event();
    check_all();
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'h02);
    ow = 1'b1;
    for (i = 0; i < 3; i++) begin
      fire(1'b0, 2);
      expect_event();
      check_all();
    end
    @(posedge mclk) capture_enable <= 1'b0;
    fire(1'b0, 2);
    check_all();
    @(posedge mclk) capture_enable <= 1'b1;
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'h02);
    check_all();
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'h04);
    ow = 1'b0;
    exp_count = 8'h00;
    for (int k = 0; k < 6; k++) exp_cap[k] = CAPTURE_RESET;
    rd_reg(EVENT_CAPTURE_CONTROL_ADDR, rd);
    chk("control", 8'h00, rd);
    check_all();
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'h03);
    ow = 1'b1;
    fire(1'b0, 2);
    check_all();
    fire(1'b1, 2);
    expect_event();
    check_all();
    // Each sampling rate; pulse spans three sample periods
    for (i = 1; i < 4; i++) begin
      wr(EVENT_CAPTURE_CONTROL_ADDR, {2'b00, 2'(i), 4'h2});
      fire(1'b0, 3 * (2 << i) + 2);
      expect_event();
      check_all();
    end
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'h02);
    for (i = 0; i < 256; i++) begin
      fire(1'b0, 2);
      expect_event();
    end
    check_all();
    // Level select kept, bits 7 and 3 ignored, unmapped address reads zero
    wr(EVENT_CAPTURE_CONTROL_ADDR, 8'hca);
    rd_reg(EVENT_CAPTURE_CONTROL_ADDR, rd);
    chk("control", 8'h42, rd);
    rd_reg(8'h12, rd);
    chk("unmapped", 8'h00, rd);
    // Reset in mid-run returns every register to zero
    @(posedge mclk) reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    {ow, flag_exp, exp_count} = '0;
    for (int k = 0; k < 6; k++) exp_cap[k] = CAPTURE_RESET;
    rd_reg(EVENT_CAPTURE_CONTROL_ADDR, rd);
    chk("control", CONTROL_RESET, rd);
    check_all();
    // First event after the reset is captured in first-event mode
    fire(1'b0, 2);
    expect_event();
    check_all();
    close_out();
  end
endmodule
